// [hw/ecf_pkg.sv]
// Constants and types shared by the electronic cam follower
package ecf_pkg;
	localparam int NUM_PROFILES = 32;
	localparam int NUM_POINTS = 100;
	localparam int CLK_PERIOD_NS = 5;
	localparam int SCAN_TIME_NS = 5000;
	localparam int SCAN_CYCLES = (SCAN_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FRAC_BITS = 8;
	localparam int T_BITS = 16;
	localparam int DIV_STEPS = 17;
	localparam logic [15:0] SCALE_ONE = 16'h0100;
	localparam logic [5:0] REAL_LO = 6'h01;
	localparam logic [5:0] REAL_HI = 6'h20;
	localparam logic [5:0] VIRT_LO = 6'h25;
	localparam logic [5:0] VIRT_HI = 6'h28;
	localparam logic [5:0] ENC_LO = 6'h29;
	localparam logic [5:0] ENC_HI = 6'h2a;
	localparam logic [1:0] CLS_NONE = 2'h0;
	localparam logic [1:0] CLS_REAL = 2'h1;
	localparam logic [1:0] CLS_VIRT = 2'h2;
	localparam logic [1:0] CLS_ENC = 2'h3;
	localparam logic [1:0] ORG_ZERO = 2'h0;
	localparam logic [1:0] ORG_START = 2'h1;
	localparam logic [15:0] ERR_PROFILE = 16'h1115;
	localparam logic [15:0] ERR_ORIGIN = 16'h1116;
	localparam logic [15:0] ERR_LEADER = 16'h1117;
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h04;
	localparam logic [7:0] OFS_LSHIFT = 8'h08;
	localparam logic [7:0] OFS_FSHIFT = 8'h0c;
	localparam logic [7:0] OFS_SCALE = 8'h10;
	localparam logic [7:0] OFS_LEADIN = 8'h14;
	localparam logic [7:0] OFS_LOCKPT = 8'h18;
	localparam logic [7:0] OFS_TADDR = 8'h1c;
	localparam logic [7:0] OFS_TX = 8'h20;
	localparam logic [7:0] OFS_TY = 8'h24;
	localparam logic [7:0] OFS_SLOPE = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2c;
	localparam logic [7:0] OFS_FPOS = 8'h30;
	localparam logic [7:0] OFS_PASSES = 8'h34;
	localparam int CTL_ENGAGE = 0;
	localparam int CTL_DISENGAGE = 1;
	localparam int TA_CUBIC = 16;
	localparam int STS_LOCKED = 8;
	localparam int STS_ERROR = 9;
	typedef struct packed {
		logic [5:0] profileNum;
		logic [1:0] originSel;
		logic feedbackSel;
		logic [5:0] leaderSel;
	} ecf_cfg_t;
	typedef struct packed {
		logic cubic;
		logic signed [31:0] y;
		logic signed [31:0] x;
	} ecf_point_t;
	typedef enum logic [4:0] {
		MD_IDLE = 5'b00001,
		MD_ALIGN = 5'b00010,
		MD_WAIT = 5'b00100,
		MD_APPROACH = 5'b01000,
		MD_LOCKED = 5'b10000
	} ecf_mode_t;
	typedef enum logic [4:0] {
		CP_IDLE = 5'b00001,
		CP_SEEK = 5'b00010,
		CP_DIV = 5'b00100,
		CP_EVAL = 5'b01000,
		CP_BLEND = 5'b10000
	} ecf_calc_t;
endpackage : ecf_pkg

// [hw/ecf_cam_follower.sv]
// Electronic cam engine with APB register slave
//Contract
//RULE1: Follower set-point comes from profile lookup at the leader position.
//RULE2: Thirty-two profiles, any profile usable by the follower.
//RULE3: Each profile holds one hundred points.
//RULE4: Disengage command or aborting motion ends cam following.
//RULE5: Leader select 1-32 real, 37-40 virtual, 41-42 encoder.
//RULE6: Leader shift moves table; follower shift moves output.
//RULE7: Scale factors multiply leader and follower coordinates of points.
//RULE8: Lock point ends sync; lead-in length precedes it.
//RULE9: Too short first approach moves sync into second table cycle.
//RULE10: Physical lock point uses leader shift and leader scale.
//RULE11: Follower waits stopped; sync start steps by table lengths.
//RULE12: Scales affect lock point; shift and lead-in unscaled.
//RULE13: Locked indication asserts when synchronous following begins.
//RULE14: Pass-done pulse lasts one scan per full table pass.
//RULE15: Origin select only 0 or 1, else error.
//RULE16: Origin zero or leader position at command start.
//RULE17: Leader feedback select: command or actual position.
//RULE18: Profile number 1-32, else error 0x1115.
//RULE19: Points hold leader, follower and linear/cubic type.
//RULE20: Slopes used only for cubic first or last section.
//RULE21: Linear section interpolates straight between bounding points.
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
module ecf_cam_follower #(
	parameter int PROFILES = ecf_pkg::NUM_PROFILES,
	parameter int POINTS = ecf_pkg::NUM_POINTS,
	parameter int SCAN_CYC = ecf_pkg::SCAN_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic signed [31:0] leaderCmdPos,
	input wire logic signed [31:0] leaderActPos,
	input wire logic signed [31:0] followerPos,
	input wire logic abortIn,
	output logic signed [31:0] followerSetPoint,
	output logic lockedInd,
	output logic passDonePulse,
	output logic engaged,
	output logic cmdError,
	output logic [5:0] leaderIndex,
	output logic [1:0] leaderClass
);
	import ecf_pkg::*;

	localparam int DEPTH = PROFILES * POINTS;
	localparam logic [6:0] LAST_SEG = 7'(POINTS - 2);

	if (POINTS < 2 || POINTS > 127 || DEPTH > 4096 || PROFILES > 63 || SCAN_CYC < 3 * POINTS) begin : g_chk
		$error("ecf_cam_follower: unsupported parameters");
	end

	ecf_point_t camMem [DEPTH];
	logic signed [15:0] startSlope [PROFILES];
	logic signed [15:0] endSlope [PROFILES];

	logic pready_ff, pslverr_ff;
	logic [31:0] prdata_ff;
	ecf_cfg_t cfg_ff;
	logic signed [31:0] leaderShift_ff, followerShift_ff, leadIn_ff, lockPoint_ff, tblX_ff;
	logic signed [15:0] leaderScale_ff, followerScale_ff;
	logic [16:0] tblAddr_ff;
	ecf_mode_t mode_ff;
	ecf_calc_t calc_ff;
	logic [4:0] prof_ff;
	logic [6:0] k_ff;
	logic [4:0] divCnt_ff;
	logic divPass_ff, approach_ff;
	logic [16:0] q_ff;
	logic signed [47:0] uS_ff, rem_ff, den_ff;
	logic signed [31:0] origin_ff, fStart_ff, cycBase_ff, lockPhys_ff, aStart_ff, camY_ff;
	logic signed [31:0] setPoint_ff;
	logic locked_ff, pass_ff, engaged_ff, error_ff;
	logic [15:0] errCode_ff;
	logic [31:0] passCount_ff;
	logic [5:0] leaderIndex_ff;
	logic [1:0] leaderClass_ff;
	logic [15:0] scanCnt_ff;
	logic scanTick_ff;

	logic acc, wr, engCmd, disCmd;
	logic [31:0] rdData;
	logic rdErr;
	logic [1:0] cls;
	logic signed [31:0] lead, uRaw, per, lockScaled, camOut, blend;
	logic [11:0] base, wIdx;
	ecf_point_t p0, p1, pLast;
	logic signed [47:0] xs0, xs1, lastXs;
	logic signed [35:0] tq, t2, t3, sh, h10, h11, shape;
	logic signed [63:0] yEval, ys, slopeTerm;
	logic signed [32:0] dy, dxRaw;

	assign acc = psel & penable & ~pready_ff;
	assign wr = psel & penable & pwrite & pready_ff;
	assign engCmd = wr && paddr == OFS_CTRL && pwdata[CTL_ENGAGE];
	assign disCmd = (wr && paddr == OFS_CTRL && pwdata[CTL_DISENGAGE]) || abortIn; //RULE4
	assign lead = cfg_ff.feedbackSel ? leaderActPos : leaderCmdPos; //RULE17

	always_comb begin
		if (cfg_ff.leaderSel >= REAL_LO && cfg_ff.leaderSel <= REAL_HI) begin //RULE5
			cls = CLS_REAL;
		end else if (cfg_ff.leaderSel >= VIRT_LO && cfg_ff.leaderSel <= VIRT_HI) begin //RULE5
			cls = CLS_VIRT;
		end else if (cfg_ff.leaderSel >= ENC_LO && cfg_ff.leaderSel <= ENC_HI) begin //RULE5
			cls = CLS_ENC;
		end else begin
			cls = CLS_NONE;
		end
	end

	// Table lookup; the active profile picks its own slice of the shared store
	always_comb begin
		base = 12'(prof_ff * POINTS); //RULE2
		p0 = camMem[base + 12'(k_ff)]; //RULE19
		p1 = camMem[base + 12'(k_ff) + 12'h001];
		pLast = camMem[base + 12'(POINTS - 1)]; //RULE3
		xs0 = 48'(p0.x * leaderScale_ff); //RULE7
		xs1 = 48'(p1.x * leaderScale_ff); //RULE7
		lastXs = 48'(pLast.x * leaderScale_ff);
		per = 32'(lastXs >>> FRAC_BITS);
		lockScaled = 32'(48'(lockPoint_ff * leaderScale_ff) >>> FRAC_BITS); //RULE10
		uRaw = lead - origin_ff - leaderShift_ff - cycBase_ff; //RULE6
		wIdx = 12'(tblAddr_ff[4:0] * POINTS) + 12'(tblAddr_ff[14:8]);
	end

	// Section shaping: t is the Q16 fraction through the current section
	always_comb begin
		tq = 36'(q_ff);
		t2 = 36'((tq * tq) >>> T_BITS);
		t3 = 36'((t2 * tq) >>> T_BITS);
		sh = 36'(3 * t2 - 2 * t3);
		h10 = tq - 36'(2 * t2) + t3;
		h11 = t3 - t2;
		shape = p0.cubic ? sh : tq; //RULE21
		dy = 33'(p1.y) - 33'(p0.y);
		dxRaw = 33'(p1.x) - 33'(p0.x);
		slopeTerm = 64'sh0;
		if (p0.cubic && k_ff == 7'h00) begin //RULE20
			slopeTerm = 64'(((64'(dxRaw) * startSlope[prof_ff]) >>> FRAC_BITS) * h10) >>> T_BITS;
		end else if (p0.cubic && k_ff == LAST_SEG) begin //RULE20
			slopeTerm = 64'(((64'(dxRaw) * endSlope[prof_ff]) >>> FRAC_BITS) * h11) >>> T_BITS;
		end
		yEval = 64'(p0.y) + 64'((64'(dy) * shape) >>> T_BITS) + slopeTerm; //RULE21
		ys = 64'((yEval * followerScale_ff) >>> FRAC_BITS); //RULE7
		camOut = 32'(ys) + followerShift_ff + fStart_ff; //RULE6
		blend = fStart_ff + 32'((64'(camY_ff - fStart_ff) * $signed({1'b0, q_ff})) >>> T_BITS);
	end

	always_comb begin
		rdErr = 1'b0;
		case (paddr)
			OFS_CTRL: rdData = 32'(mode_ff);
			OFS_CFG: rdData = 32'(cfg_ff);
			OFS_LSHIFT: rdData = leaderShift_ff;
			OFS_FSHIFT: rdData = followerShift_ff;
			OFS_SCALE: rdData = {followerScale_ff, leaderScale_ff};
			OFS_LEADIN: rdData = leadIn_ff;
			OFS_LOCKPT: rdData = lockPoint_ff;
			OFS_TADDR: rdData = 32'(tblAddr_ff);
			OFS_TX: rdData = tblX_ff;
			OFS_TY: rdData = 32'h0;
			OFS_SLOPE: rdData = {endSlope[tblAddr_ff[4:0]], startSlope[tblAddr_ff[4:0]]};
			OFS_STATUS: rdData = {errCode_ff, 6'h00, error_ff, locked_ff, 3'h0, mode_ff};
			OFS_FPOS: rdData = setPoint_ff;
			OFS_PASSES: rdData = passCount_ff;
			default: begin
				rdData = 32'h0;
				rdErr = 1'b1;
			end
		endcase
	end

	// One wait state keeps the read path registered
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0;
		end else begin
			pready_ff <= acc;
			pslverr_ff <= acc & rdErr;
			if (acc) begin
				prdata_ff <= pwrite ? 32'h0 : rdData;
			end
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_ff <= '0;
			leaderShift_ff <= 32'h0;
			followerShift_ff <= 32'h0;
			leaderScale_ff <= SCALE_ONE;
			followerScale_ff <= SCALE_ONE;
			leadIn_ff <= 32'h0;
			lockPoint_ff <= 32'h0;
			tblAddr_ff <= 17'h0;
			tblX_ff <= 32'h0;
		end else if (wr) begin
			case (paddr)
				OFS_CFG: cfg_ff <= ecf_cfg_t'(pwdata[$bits(ecf_cfg_t)-1:0]);
				OFS_LSHIFT: leaderShift_ff <= pwdata;
				OFS_FSHIFT: followerShift_ff <= pwdata;
				OFS_SCALE: begin
					leaderScale_ff <= pwdata[15:0];
					followerScale_ff <= pwdata[31:16];
				end
				OFS_LEADIN: leadIn_ff <= pwdata;
				OFS_LOCKPT: lockPoint_ff <= pwdata;
				OFS_TADDR: tblAddr_ff <= pwdata[16:0];
				OFS_TX: tblX_ff <= pwdata;
				default: begin
				end
			endcase
		end
	end

	// Profile store has no reset; software loads it before engaging
	always_ff @(posedge clock) begin
		// Six-bit compare: a full set of 32 profiles would wrap to zero at five bits
		if (wr && paddr == OFS_TY && tblAddr_ff[14:8] < 7'(POINTS) && 6'(tblAddr_ff[4:0]) < 6'(PROFILES)) begin
			camMem[wIdx] <= '{cubic: tblAddr_ff[TA_CUBIC], y: pwdata, x: tblX_ff}; //RULE19
		end
		if (wr && paddr == OFS_SLOPE && 6'(tblAddr_ff[4:0]) < 6'(PROFILES)) begin
			startSlope[tblAddr_ff[4:0]] <= pwdata[15:0];
			endSlope[tblAddr_ff[4:0]] <= pwdata[31:16];
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			scanCnt_ff <= 16'h0;
			scanTick_ff <= 1'b0;
		end else begin
			scanTick_ff <= scanCnt_ff == 16'(SCAN_CYC - 1);
			scanCnt_ff <= scanCnt_ff == 16'(SCAN_CYC - 1) ? 16'h0 : scanCnt_ff + 16'h1;
		end
	end

	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			leaderIndex_ff <= 6'h0;
			leaderClass_ff <= CLS_NONE;
		end else begin
			leaderIndex_ff <= cfg_ff.leaderSel;
			leaderClass_ff <= cls;
		end
	end

	// Engine: engage checks, sync alignment and per-scan cam evaluation
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			mode_ff <= MD_IDLE;
			calc_ff <= CP_IDLE;
			prof_ff <= 5'h0;
			k_ff <= 7'h0;
			divCnt_ff <= 5'h0;
			divPass_ff <= 1'b0;
			approach_ff <= 1'b0;
			q_ff <= 17'h0;
			uS_ff <= 48'sh0;
			rem_ff <= 48'sh0;
			den_ff <= 48'sh0;
			origin_ff <= 32'h0;
			fStart_ff <= 32'h0;
			cycBase_ff <= 32'h0;
			lockPhys_ff <= 32'h0;
			aStart_ff <= 32'h0;
			camY_ff <= 32'h0;
			setPoint_ff <= 32'h0;
			locked_ff <= 1'b0;
			pass_ff <= 1'b0;
			engaged_ff <= 1'b0;
			error_ff <= 1'b0;
			errCode_ff <= 16'h0;
			passCount_ff <= 32'h0;
		end else if (disCmd) begin
			mode_ff <= MD_IDLE; //RULE4
			calc_ff <= CP_IDLE;
			locked_ff <= 1'b0;
			pass_ff <= 1'b0;
			engaged_ff <= 1'b0;
		end else if (engCmd) begin
			if (cfg_ff.profileNum < 6'h01 || cfg_ff.profileNum > 6'(PROFILES)) begin
				error_ff <= 1'b1; //RULE18
				errCode_ff <= ERR_PROFILE; //RULE18
			end else if (cfg_ff.originSel != ORG_ZERO && cfg_ff.originSel != ORG_START) begin
				error_ff <= 1'b1; //RULE15
				errCode_ff <= ERR_ORIGIN; //RULE15
			end else if (cls == CLS_NONE) begin
				error_ff <= 1'b1; //RULE5
				errCode_ff <= ERR_LEADER;
			end else begin
				error_ff <= 1'b0;
				errCode_ff <= 16'h0;
				prof_ff <= 5'(cfg_ff.profileNum - 6'h01); //RULE2
				origin_ff <= cfg_ff.originSel == ORG_START ? lead : 32'h0; //RULE16
				fStart_ff <= followerPos;
				cycBase_ff <= 32'h0;
				lockPhys_ff <= (cfg_ff.originSel == ORG_START ? lead : 32'h0) + leaderShift_ff + lockScaled; //RULE12
				aStart_ff <= (cfg_ff.originSel == ORG_START ? lead : 32'h0) + leaderShift_ff + lockScaled - leadIn_ff; //RULE8
				mode_ff <= MD_ALIGN;
				calc_ff <= CP_IDLE;
				locked_ff <= 1'b0;
				pass_ff <= 1'b0;
				engaged_ff <= 1'b1;
				passCount_ff <= 32'h0;
			end
		end else begin
			case (mode_ff)
				MD_ALIGN: begin
					if (per > 0 && lead >= aStart_ff) begin
						aStart_ff <= aStart_ff + per; //RULE11
						lockPhys_ff <= lockPhys_ff + per; //RULE9
						cycBase_ff <= cycBase_ff + per;
					end else begin
						mode_ff <= MD_WAIT;
					end
				end
				MD_WAIT: begin
					if (scanTick_ff && lead >= aStart_ff) begin
						mode_ff <= MD_APPROACH; //RULE11
					end
				end
				MD_APPROACH: begin
					if (scanTick_ff && calc_ff == CP_IDLE && lead >= lockPhys_ff) begin
						mode_ff <= MD_LOCKED;
						locked_ff <= 1'b1; //RULE13
					end
				end
				MD_LOCKED, MD_IDLE: begin
				end
				default: mode_ff <= MD_IDLE;
			endcase
			if (scanTick_ff) begin
				pass_ff <= 1'b0; //RULE14
			end
			case (calc_ff)
				CP_IDLE: begin
					if (scanTick_ff && (mode_ff == MD_LOCKED || mode_ff == MD_APPROACH)) begin
						approach_ff <= mode_ff == MD_APPROACH && lead < lockPhys_ff;
						k_ff <= 7'h0;
						divPass_ff <= 1'b0;
						calc_ff <= CP_SEEK;
						if (mode_ff == MD_LOCKED && per > 0 && uRaw >= per) begin
							cycBase_ff <= cycBase_ff + per;
							pass_ff <= 1'b1; //RULE14
							passCount_ff <= passCount_ff + 32'h1;
							uS_ff <= 48'(uRaw - per) <<< FRAC_BITS;
						end else if (mode_ff == MD_LOCKED && uRaw < 0) begin
							cycBase_ff <= cycBase_ff - per;
							uS_ff <= 48'(uRaw + per) <<< FRAC_BITS;
						end else if (uRaw < 0) begin
							uS_ff <= 48'(uRaw + per) <<< FRAC_BITS;
						end else begin
							uS_ff <= 48'(uRaw) <<< FRAC_BITS;
						end
					end
				end
				CP_SEEK: begin
					if (k_ff == LAST_SEG || xs1 > uS_ff) begin
						q_ff <= 17'h0;
						divCnt_ff <= 5'h0;
						den_ff <= xs1 - xs0;
						rem_ff <= uS_ff < xs0 ? 48'sh0 : (uS_ff > xs1 ? xs1 - xs0 : uS_ff - xs0);
						calc_ff <= xs1 > xs0 ? CP_DIV : CP_EVAL;
					end else begin
						k_ff <= k_ff + 7'h1; //RULE1
					end
				end
				CP_DIV: begin
					q_ff <= {q_ff[15:0], rem_ff >= den_ff};
					rem_ff <= (rem_ff >= den_ff ? rem_ff - den_ff : rem_ff) <<< 1;
					divCnt_ff <= divCnt_ff + 5'h1;
					if (divCnt_ff == 5'(DIV_STEPS - 1)) begin
						calc_ff <= divPass_ff ? CP_BLEND : CP_EVAL;
					end
				end
				CP_EVAL: begin
					camY_ff <= camOut;
					if (approach_ff && leadIn_ff > 0) begin
						// Lead-in: follower ramps from its start toward the cam curve
						divPass_ff <= 1'b1;
						q_ff <= 17'h0;
						divCnt_ff <= 5'h0;
						den_ff <= 48'(leadIn_ff);
						rem_ff <= lead < aStart_ff ? 48'sh0 : 48'(lead - aStart_ff);
						calc_ff <= CP_DIV;
					end else begin
						setPoint_ff <= camOut; //RULE1
						calc_ff <= CP_IDLE;
					end
				end
				CP_BLEND: begin
					setPoint_ff <= blend; //RULE8
					calc_ff <= CP_IDLE;
				end
				default: calc_ff <= CP_IDLE;
			endcase
		end
	end

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign followerSetPoint = setPoint_ff;
	assign lockedInd = locked_ff;
	assign passDonePulse = pass_ff;
	assign engaged = engaged_ff;
	assign cmdError = error_ff;
	assign leaderIndex = leaderIndex_ff;
	assign leaderClass = leaderClass_ff;
endmodule : ecf_cam_follower

// [dv/ecf_cam_follower_asserts.sv]
// Port checker for the cam follower
`timescale 1ns/1ps
module ecf_cam_follower_asserts #(
	parameter int SCAN_CYC = ecf_pkg::SCAN_CYCLES
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic abortIn,
	input wire logic lockedInd,
	input wire logic passDonePulse,
	input wire logic engaged,
	input wire logic cmdError,
	input wire logic [5:0] leaderIndex,
	input wire logic [1:0] leaderClass
);
	import ecf_pkg::*;
	logic [15:0] highCnt_ff;
	// Counts pulse length; a pulse cut short by disengage is not judged
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			highCnt_ff <= 16'h0000;
		end else if (passDonePulse) begin
			highCnt_ff <= highCnt_ff + 16'h0001;
		end else begin
			highCnt_ff <= 16'h0000;
		end
	end
	function automatic logic [1:0] clsOf(input logic [5:0] s);
		return (s >= REAL_LO && s <= REAL_HI) ? CLS_REAL :
			(s >= VIRT_LO && s <= VIRT_HI) ? CLS_VIRT :
			(s >= ENC_LO && s <= ENC_HI) ? CLS_ENC : CLS_NONE;
	endfunction : clsOf
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	apb_wait_a: assert property (psel && penable && !pready |=> pready) else $error("pready late");
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready held");
	slverr_rdy_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	slverr_data_a: assert property (pslverr |-> prdata == 32'h00000000) else $error("refused read not zero");
	pass_len_a: assert property (passDonePulse |-> highCnt_ff < SCAN_CYC) else $error("pulse too long");
	pass_full_a: assert property ($fell(passDonePulse) && engaged |-> highCnt_ff == SCAN_CYC)
		else $error("pulse too short");
	pulse_locked_a: assert property ($rose(passDonePulse) |-> lockedInd) else $error("pulse while unlocked");
	abort_ends_a: assert property (abortIn |=> !engaged && !lockedInd) else $error("abort ignored");
	locked_eng_a: assert property (lockedInd |-> engaged) else $error("locked while idle");
	class_map_a: assert property (engaged && $stable(leaderIndex) |-> leaderClass == clsOf(leaderIndex))
		else $error("leader class wrong");
	cover property ($rose(lockedInd));
	cover property ($rose(passDonePulse));
	cover property ($rose(cmdError));
	cover property (pready && pslverr);
endmodule : ecf_cam_follower_asserts
bind ecf_cam_follower ecf_cam_follower_asserts #(.SCAN_CYC(SCAN_CYC)) chk (.clock(clock), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .abortIn(abortIn),
	.lockedInd(lockedInd), .passDonePulse(passDonePulse), .engaged(engaged), .cmdError(cmdError),
	.leaderIndex(leaderIndex), .leaderClass(leaderClass));

// [dv/ecf_leader_model.sv]
// Leader axis and its drive, moving one unit per clock toward a target
`timescale 1ns/1ps
module ecf_leader_model (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic signed [31:0] targetPos,
	output logic signed [31:0] leaderCmdPos,
	output logic signed [31:0] leaderActPos
);
	logic signed [31:0] cmd_ff;
	logic signed [31:0] act_ff;
	// Slow travel keeps wrap below one table length per scan
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cmd_ff <= 32'sh0;
		end else if (cmd_ff < targetPos) begin
			cmd_ff <= cmd_ff + 32'sh1;
		end else if (cmd_ff > targetPos) begin
			cmd_ff <= cmd_ff - 32'sh1;
		end
	end
	// Drive reports one cycle late, as over a link
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			act_ff <= 32'sh0;
		end else begin
			act_ff <= cmd_ff;
		end
	end
	assign leaderCmdPos = cmd_ff;
	assign leaderActPos = act_ff;
endmodule : ecf_leader_model

// [dv/tb_top.sv]
// Self-checking bench for the cam follower
`timescale 1ns/1ps
module tb_top;
	import ecf_pkg::*;
	localparam int SCANS = 300;
	localparam int SETTLE = 2 * SCANS + 150;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready, pslverr, lockedInd, passDonePulse, engaged, cmdError, rerr;
	logic signed [31:0] leaderCmdPos, leaderActPos, followerSetPoint;
	logic signed [31:0] followerPos = 32'sh0;
	logic signed [31:0] targetPos = 32'sh0;
	logic abortIn = 1'b0;
	logic [5:0] leaderIndex;
	logic [1:0] leaderClass;
	logic [31:0] rdat, hold;
	ecf_cfg_t cfg;
	int err_count = 0;
	int checks = 0;
	logic [29:0] badCase [8] = '{{ERR_PROFILE, 6'h00, 2'h0, 6'h01}, {ERR_PROFILE, 6'h21, 2'h0, 6'h01},
		{ERR_ORIGIN, 6'h20, 2'h2, 6'h01}, {ERR_ORIGIN, 6'h20, 2'h3, 6'h01}, {ERR_LEADER, 6'h20, 2'h0, 6'h00},
		{ERR_LEADER, 6'h20, 2'h0, 6'h21}, {ERR_LEADER, 6'h20, 2'h0, 6'h24}, {ERR_LEADER, 6'h20, 2'h0, 6'h2b}};
	logic [7:0] goodLead [6] = '{{6'h01, CLS_REAL}, {6'h20, CLS_REAL}, {6'h25, CLS_VIRT}, {6'h28, CLS_VIRT},
		{6'h29, CLS_ENC}, {6'h2a, CLS_ENC}};
	always #2.5 clock = ~clock;
	ecf_cam_follower #(.SCAN_CYC(SCANS)) uut (.clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.leaderCmdPos(leaderCmdPos), .leaderActPos(leaderActPos), .followerPos(followerPos), .abortIn(abortIn),
		.followerSetPoint(followerSetPoint), .lockedInd(lockedInd), .passDonePulse(passDonePulse),
		.engaged(engaged), .cmdError(cmdError), .leaderIndex(leaderIndex), .leaderClass(leaderClass));
	ecf_leader_model leader (.clock(clock), .sys_rst(sys_rst), .targetPos(targetPos),
		.leaderCmdPos(leaderCmdPos), .leaderActPos(leaderActPos));
	task automatic finish_test();
		$display("checks=%0d errors=%0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= addr;
		pwdata <= wdata;
		@(posedge clock);
		penable <= 1'b1;
		// Waits for the answer however late; only the watchdog ends a hung access
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : xfer
	task automatic wr(input logic [7:0] addr, input logic [31:0] data);
		xfer(1'b1, addr, data);
	endtask : wr
	task automatic rdm(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
		xfer(1'b0, addr, 32'h00000000);
		check(rdat & mask, exp);
	endtask : rdm
	task automatic engage(input logic [5:0] prof, input logic [1:0] org, input logic fb, input logic [5:0] lead);
		cfg = '{profileNum: prof, originSel: org, feedbackSel: fb, leaderSel: lead};
		wr(OFS_CFG, 32'(cfg));
		wr(OFS_CTRL, 32'h00000001);
		repeat (3) @(posedge clock);
	endtask : engage
	// Waits for the leader to arrive, then two scans plus 150 clocks for the engine to catch up
	task automatic moveTo(input int pos);
		int n;
		targetPos <= pos;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (leaderCmdPos !== 32'(pos) && n < 4000);
		if (n >= 4000) begin
			check(leaderCmdPos, 32'(pos));
		end
		repeat (SETTLE) @(posedge clock);
	endtask : moveTo
	initial begin
		#300000;
		err_count++;
		finish_test();
	end
	initial begin
		repeat (12) @(posedge clock);
		sys_rst <= 1'b0;
		rdm(OFS_SCALE, 32'hffffffff, 32'h01000100);
		xfer(1'b0, 8'hfc, 32'h00000000);
		check(rdat, 32'h00000000);
		check({31'h0, rerr}, 32'h00000001);
		for (int i = 0; i < NUM_POINTS; i++) begin
			wr(OFS_TADDR, (32'(i) << 8) | 32'h0000001f);
			wr(OFS_TX, 32'(i * 16));
			wr(OFS_TY, 32'(i * 32));
		end
		wr(OFS_SLOPE, 32'h00000000);
		$display("test load done");
		for (int i = 0; i < 8; i++) begin
			engage(badCase[i][13:8], badCase[i][7:6], 1'b0, badCase[i][5:0]);
			rdm(OFS_STATUS, 32'hffff0200, {badCase[i][29:14], 16'h0200});
			check({30'h0, cmdError, engaged}, 32'h00000002);
		end
		$display("test refuse done");
		for (int i = 0; i < 6; i++) begin
			engage(6'h20, 2'(i % 2), 1'(i % 2), goodLead[i][7:2]);
			check({24'h0, leaderIndex, leaderClass}, {24'h0, goodLead[i]});
			check({31'h0, cmdError}, 32'h00000000);
			wr(OFS_CTRL, 32'h00000002);
		end
		$display("test select done");
		wr(OFS_LSHIFT, 32'h00000000);
		wr(OFS_FSHIFT, 32'h00000040);
		wr(OFS_LEADIN, 32'h00000190);
		wr(OFS_LOCKPT, 32'h00000320);
		engage(6'h20, ORG_ZERO, 1'b0, 6'h01);
		repeat (SETTLE) @(posedge clock);
		rdm(OFS_CTRL, 32'h0000001f, 32'h00000004);
		hold = followerSetPoint;
		repeat (SCANS) @(posedge clock);
		check(followerSetPoint, hold);
		check({31'h0, lockedInd}, 32'h00000000);
		moveTo(1000);
		check({31'h0, lockedInd}, 32'h00000001);
		rdm(OFS_CTRL, 32'h0000001f, 32'h00000010);
		check(followerSetPoint, 32'h00000810);
		moveTo(1784);
		rdm(OFS_PASSES, 32'hffffffff, 32'h00000001);
		check(followerSetPoint, 32'h000001d0);
		wr(OFS_SCALE, 32'h02000100);
		repeat (SETTLE) @(posedge clock);
		check(followerSetPoint, 32'h00000360);
		wr(OFS_SCALE, 32'h01000100);
		wr(OFS_CTRL, 32'h00000002);
		repeat (3) @(posedge clock);
		check({30'h0, engaged, lockedInd}, 32'h00000000);
		$display("test lock done");
		moveTo(500);
		engage(6'h20, ORG_ZERO, 1'b0, 6'h01);
		repeat (SETTLE) @(posedge clock);
		rdm(OFS_CTRL, 32'h0000001f, 32'h00000004);
		moveTo(1900);
		check({31'h0, lockedInd}, 32'h00000000);
		moveTo(2500);
		check({31'h0, lockedInd}, 32'h00000001);
		check(followerSetPoint, 32'h00000768);
		wr(OFS_TADDR, 32'h0001391f);
		wr(OFS_TX, 32'h00000390);
		wr(OFS_TY, 32'h00000720);
		repeat (SETTLE) @(posedge clock);
		check(followerSetPoint, 32'h00000765);
		wr(OFS_LSHIFT, 32'h00000010);
		repeat (SETTLE) @(posedge clock);
		check(followerSetPoint, 32'h00000748);
		abortIn <= 1'b1;
		@(posedge clock);
		abortIn <= 1'b0;
		repeat (3) @(posedge clock);
		check({30'h0, engaged, lockedInd}, 32'h00000000);
		$display("test realign done");
		finish_test();
	end
endmodule : tb_top
